/* dv/tb_timer12_count_ctrl.sv */
`include "timer12_cfg.svh"
// ----
// Bench
// ----
module tb_timer12_count_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst_n = 1'b0, count_tick = 1'b0, mode_wr = 1'b0, ovf_clear = 1'b0;
   logic periph_put = 1'b0, periph_get = 1'b0, get_seen = 1'b0, overflow_detect_flag, irq_req;
   logic [3:0] mode_wdata = 4'h0, mode_rdata;
   logic [6:0] periph_addr = 7'h00;
   timer12_pkg::buf_t put_data = 16'h0000, transfer_buffer;
   logic [17:0] notes[$], exp_v;
   int fail_count = 0, comparisons = 0, seed = 49043, n;
   // Free-running clock
   always #5 ref_clk = ~ref_clk;
   timer12_count_ctrl i_timer12_count_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .count_tick(count_tick),
      .mode_wr(mode_wr), .mode_wdata(mode_wdata), .mode_rdata(mode_rdata), .ovf_clear(ovf_clear),
      .overflow_detect_flag(overflow_detect_flag), .periph_addr(periph_addr), .periph_put(periph_put),
      .put_data(put_data), .periph_get(periph_get), .transfer_buffer(transfer_buffer), .irq_req(irq_req));
   // Expected note: overflow, irq, upper nibble always zero, count
   function automatic logic [17:0] e(input logic o, input logic i, input logic [11:0] c);
      return {o, i, 4'h0, c};
   endfunction
   task automatic step(input logic [3:0] d);
      mode_wdata <= d;
      mode_wr <= 1'b1;
      @(posedge ref_clk);
      mode_wr <= 1'b0;
   endtask
   task automatic tick(input int k);
      repeat (k) begin
         count_tick <= 1'b1;
         @(posedge ref_clk);
      end
      count_tick <= 1'b0;
   endtask
   task automatic put(input logic [15:0] v);
      periph_addr <= 7'h46;
      put_data <= v;
      periph_put <= 1'b1;
      @(posedge ref_clk);
      periph_put <= 1'b0;
   endtask
   // Extra idle edge lets the buffer land before the next request
   task automatic chk(input logic [6:0] a, input logic [17:0] x);
      periph_addr <= a;
      periph_get <= 1'b1;
      notes.push_back(x);
      @(posedge ref_clk);
      periph_get <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic test_done;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Result watcher: buffer is valid the edge after a get
   always @(posedge ref_clk) begin
      if (get_seen) begin
         exp_v = notes.pop_front();
         comparisons++;
         if ({overflow_detect_flag, irq_req, transfer_buffer} !== exp_v) begin
            fail_count++;
            $display("mismatch ovf_irq_buffer expected %h seen %h", exp_v,
               {overflow_detect_flag, irq_req, transfer_buffer});
         end
      end
      get_seen <= periph_get;
   end
   // Watchdog, well beyond the long free-run walk
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      test_done;
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk(7'h47, e(1'b0, 1'b0, `TMR_COUNT_RESET));
      chk(7'h46, e(1'b0, 1'b0, `TMR_COMPARE_RESET));
      tick(4);
      chk(7'h47, e(1'b0, 1'b0, 12'h000));
      n = ($random(seed) & 15) + 1;
      step(4'h1);
      tick(n);
      chk(7'h47, e(1'b0, 1'b0, n[11:0]));
      step(4'h0);
      tick(3);
      chk(7'h47, e(1'b0, 1'b0, n[11:0]));
      step(4'h3);
      tick(2);
      chk(7'h47, e(1'b0, 1'b0, 12'h002));
      // Random top nibble on the write must not reach the compare register
      n = $random(seed);
      put({n[3:0], 12'h003});
      chk(7'h46, e(1'b0, 1'b0, 12'h003));
      step(4'h7);
      tick(3);
      chk(7'h47, e(1'b0, 1'b1, 12'h003));
      tick(1);
      chk(7'h47, e(1'b0, 1'b0, 12'h000));
      tick(1);
      chk(7'h47, e(1'b0, 1'b0, 12'h001));
      put(16'h0002);
      step(4'h3);
      tick(2);
      chk(7'h47, e(1'b0, 1'b1, 12'h002));
      tick(1);
      chk(7'h47, e(1'b0, 1'b0, 12'h003));
      // Read while ticking: snapshot is the count before the sampling edge
      count_tick <= 1'b1;
      chk(7'h47, e(1'b0, 1'b0, 12'h003));
      count_tick <= 1'b0;
      put(16'h0FFF);
      step(4'h3);
      tick(4095);
      chk(7'h47, e(1'b0, 1'b1, `TMR_COUNT_MAX));
      tick(1);
      chk(7'h47, e(1'b1, 1'b1, `TMR_COUNT_MAX));
      tick(2);
      chk(7'h47, e(1'b1, 1'b1, `TMR_COUNT_MAX));
      ovf_clear <= 1'b1;
      @(posedge ref_clk);
      ovf_clear <= 1'b0;
      chk(7'h2A, e(1'b0, 1'b1, 12'h000));
      // One more edge so the watcher makes the last compare before the end
      @(posedge ref_clk);
      test_done;
   end
endmodule // tb_timer12_count_ctrl

/* dv/timer12_count_ctrl_props.sv */
// ----
// Port checks
// ----
module timer12_props (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic count_tick,
   input wire logic mode_wr,
   input wire logic [3:0] mode_wdata,
   input wire logic [3:0] mode_rdata,
   input wire logic ovf_clear,
   input wire logic overflow_detect_flag,
   input wire logic [6:0] periph_addr,
   input wire logic periph_put,
   input wire logic periph_get,
   input wire timer12_pkg::buf_t transfer_buffer,
   input wire logic irq_req
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Ports only, so the count itself is judged through irq and overflow
   a_upper_zero: assert property (transfer_buffer[15:12] == 4'h0) else $error("upper bits set");
   a_clear_reads_zero: assert property (mode_rdata[1] == 1'b0) else $error("clear bit read");
   a_mode_echo: assert property (mode_wr |=> mode_rdata[2] == $past(mode_wdata[2])) else $error("mode");
   a_ovf_holds: assert property (overflow_detect_flag && !ovf_clear && !mode_wr |=> overflow_detect_flag)
      else $error("overflow dropped");
   a_ovf_cause: assert property ($rose(overflow_detect_flag) |-> $past(count_tick && mode_rdata[0]))
      else $error("overflow without tick");
   a_irq_cause: assert property ($rose(irq_req) |-> $past(count_tick || periph_put || mode_wr))
      else $error("irq without cause");
   a_modulo_wrap: assert property (irq_req && count_tick && mode_rdata[0] && mode_rdata[2] && !mode_wr
      && !periph_put && !overflow_detect_flag |=> !irq_req) else $error("no wrap");
   a_get_other_zero: assert property (periph_get && periph_addr != 7'h46 && periph_addr != 7'h47
      |=> transfer_buffer == 16'h0000) else $error("stray get data");
   a_stopped_irq: assert property (!mode_rdata[0] && !mode_wr && !periph_put |=> $stable(irq_req))
      else $error("stopped counter moved");
   c_wrap: cover property (irq_req && count_tick && mode_rdata[2]);
   c_ovf: cover property ($rose(overflow_detect_flag));
   c_get: cover property (periph_get && periph_addr == 7'h47);
endmodule // timer12_props

bind timer12_count_ctrl timer12_props i_timer12_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .count_tick(count_tick), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .mode_rdata(mode_rdata),
   .ovf_clear(ovf_clear), .overflow_detect_flag(overflow_detect_flag), .periph_addr(periph_addr),
   .periph_put(periph_put), .periph_get(periph_get), .transfer_buffer(transfer_buffer), .irq_req(irq_req));

/* src/coincidence_detect.sv */
// ----------------------------------------------------------------
// Equality of count and compare value
// ----------------------------------------------------------------
module coincidence_detect (
   input wire timer12_pkg::count_t count_in,
   input wire timer12_pkg::count_t compare_in,
   output logic match
);

   // Pure compare; the caller decides what a match does
   always_comb begin
      match = (count_in == compare_in);
   end

endmodule // coincidence_detect

/* src/timer12_cfg.svh */
`ifndef TIMER12_CFG_SVH
`define TIMER12_CFG_SVH

// ----------------------------------------------------------------
// Peripheral addresses reached through the transfer buffer
// ----------------------------------------------------------------
`define TMR_ADDR_COMPARE 7'h46
`define TMR_ADDR_COUNTER 7'h47

// ----------------------------------------------------------------
// Mode control nibble layout
// ----------------------------------------------------------------
`define TMR_MODE_RUN_BIT 0
`define TMR_MODE_CLEAR_BIT 1
`define TMR_MODE_REPEAT_BIT 2

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define TMR_COUNT_RESET 12'h000
`define TMR_COUNT_MAX 12'hFFF
`define TMR_COMPARE_RESET 12'hFFF
`define TMR_BUF_UPPER_ZERO 4'h0

`endif

/* src/timer12_count_ctrl.sv */
`include "timer12_cfg.svh"

// Overview of operation
// - Counter advances only after software sets the run flag.
// - Writing one to the clear flag zeroes the counter.
// - Modulo mode also zeroes the counter on a compare match.
// - Repeat select flag picks free-run or modulo counting of the 12-bit counter.
// - In free-run mode a match does not clear; counting carries on.
// - Interrupt request is raised whenever count equals compare, either mode.
// - Free-run counts to FFF, next clock sets overflow flag and stops.
// - Transfer buffer carries count in low 12 bits; upper 4 read zero.
// - Counter may be read while running; software accepts possible inaccuracy.
// - The clear flag always reads back as zero.
// - Modulo counts to compare value, next clock returns to zero, resumes.
// - Counter increments on each count clock once counting is enabled.
// - While overflow flag is set the counter stays stopped.
module timer12_count_ctrl (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic count_tick,
   input wire logic mode_wr,
   input wire logic [3:0] mode_wdata,
   output logic [3:0] mode_rdata,
   input wire logic ovf_clear,
   output logic overflow_detect_flag,
   input wire logic [6:0] periph_addr,
   input wire logic periph_put,
   input wire timer12_pkg::buf_t put_data,
   input wire logic periph_get,
   output timer12_pkg::buf_t transfer_buffer,
   output logic irq_req
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Widen a 12-bit value to the buffer with the top nibble forced low
   function automatic timer12_pkg::buf_t to_buffer(input timer12_pkg::count_t v);
      to_buffer = {`TMR_BUF_UPPER_ZERO, v};
   endfunction

   // Increment that wraps within 12 bits
   function automatic timer12_pkg::count_t inc12(input timer12_pkg::count_t v);
      inc12 = timer12_pkg::count_t'(v + 12'h001);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic run_ff;
   logic nxt_run;
   timer12_pkg::count_mode_e mode_ff;
   timer12_pkg::count_mode_e nxt_mode;
   timer12_pkg::count_t counter_value_ff;
   timer12_pkg::count_t nxt_counter_value;
   timer12_pkg::count_t compare_value_ff;
   timer12_pkg::count_t nxt_compare_value;
   logic ovf_ff;
   logic nxt_ovf;
   logic irq_ff;
   logic nxt_irq;
   timer12_pkg::buf_t buf_ff;
   timer12_pkg::buf_t nxt_buf;
   logic match_now;
   logic match_next;
   logic clear_cmd;
   logic advance;

   // ----------------------------------------------------------------
   // Coincidence detection
   // ----------------------------------------------------------------

   // Current count against the compare register
   coincidence_detect u_match_now (
      .count_in(counter_value_ff),
      .compare_in(compare_value_ff),
      .match(match_now)
   );

   // Look-ahead compare so the request lines up with the count it belongs to
   coincidence_detect u_match_next (
      .count_in(nxt_counter_value),
      .compare_in(nxt_compare_value),
      .match(match_next)
   );

   // ----------------------------------------------------------------
   // Mode control
   // ----------------------------------------------------------------

   // Clear bit is not stored, so it acts once per write and reads zero
   always_comb begin
      clear_cmd = mode_wr & mode_wdata[`TMR_MODE_CLEAR_BIT];
      nxt_run = run_ff;
      nxt_mode = mode_ff;
      if (mode_wr) begin
         nxt_run = mode_wdata[`TMR_MODE_RUN_BIT];
         nxt_mode = mode_wdata[`TMR_MODE_REPEAT_BIT] ? timer12_pkg::MODE_MODULO
                                                     : timer12_pkg::MODE_FREE_RUN;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         run_ff <= 1'b0;
         mode_ff <= timer12_pkg::MODE_FREE_RUN;
      end else begin
         run_ff <= nxt_run;
         mode_ff <= nxt_mode;
      end
   end

   // Readback: clear flag position and top bit always zero
   always_comb begin
      mode_rdata = 4'h0;
      mode_rdata[`TMR_MODE_RUN_BIT] = run_ff;
      mode_rdata[`TMR_MODE_REPEAT_BIT] = (mode_ff == timer12_pkg::MODE_MODULO);
      mode_rdata[`TMR_MODE_CLEAR_BIT] = 1'b0;
   end

   // ----------------------------------------------------------------
   // Count block
   // ----------------------------------------------------------------

   // A tick only counts while running and not stopped by overflow;
   // a stopped counter simply keeps its value
   always_comb begin
      advance = count_tick & run_ff & ~ovf_ff;
      nxt_counter_value = counter_value_ff;
      nxt_ovf = ovf_ff;
      if (ovf_clear) begin
         nxt_ovf = 1'b0;
      end
      if (clear_cmd) begin
         // Software clear beats a tick in the same cycle
         nxt_counter_value = `TMR_COUNT_RESET;
      end else if (advance) begin
         case (mode_ff)
            timer12_pkg::MODE_MODULO: begin
               if (match_now) begin
                  nxt_counter_value = `TMR_COUNT_RESET;
               end else begin
                  nxt_counter_value = inc12(counter_value_ff);
               end
            end
            timer12_pkg::MODE_FREE_RUN: begin
               if (counter_value_ff == `TMR_COUNT_MAX) begin
                  // Hold at FFF; the set wins over a clear in the same cycle
                  nxt_ovf = 1'b1;
               end else begin
                  nxt_counter_value = inc12(counter_value_ff);
               end
            end
            default: begin
               nxt_counter_value = counter_value_ff;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         counter_value_ff <= `TMR_COUNT_RESET;
         ovf_ff <= 1'b0;
      end else begin
         counter_value_ff <= nxt_counter_value;
         ovf_ff <= nxt_ovf;
      end
   end

   assign overflow_detect_flag = ovf_ff;

   // ----------------------------------------------------------------
   // Compare register and interrupt request
   // ----------------------------------------------------------------

   // Zero is a prohibited compare value; it is stored as written, and
   // the hardware does not guard against it
   always_comb begin
      nxt_compare_value = compare_value_ff;
      if (periph_put && (periph_addr == `TMR_ADDR_COMPARE)) begin
         nxt_compare_value = put_data[11:0];
      end
      nxt_irq = match_next;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         compare_value_ff <= `TMR_COMPARE_RESET;
         irq_ff <= 1'b0;
      end else begin
         compare_value_ff <= nxt_compare_value;
         irq_ff <= nxt_irq;
      end
   end

   assign irq_req = irq_ff;

   // ----------------------------------------------------------------
   // Transfer buffer
   // ----------------------------------------------------------------

   // Reads are allowed mid-count; the snapshot is the count before this edge
   always_comb begin
      nxt_buf = buf_ff;
      if (periph_get) begin
         if (periph_addr == `TMR_ADDR_COUNTER) begin
            nxt_buf = to_buffer(counter_value_ff);
         end else if (periph_addr == `TMR_ADDR_COMPARE) begin
            nxt_buf = to_buffer(compare_value_ff);
         end else begin
            nxt_buf = 16'h0000;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         buf_ff <= 16'h0000;
      end else begin
         buf_ff <= nxt_buf;
      end
   end

   assign transfer_buffer = buf_ff;

endmodule // timer12_count_ctrl

/* src/timer12_pkg.sv */
package timer12_pkg;

   // Count width and transfer buffer width
   typedef logic [11:0] count_t;
   typedef logic [15:0] buf_t;

   // Operating modes picked by the repeat select flag
   typedef enum logic {
      MODE_FREE_RUN,
      MODE_MODULO
   } count_mode_e;

endpackage
